// ---- bpl_pkg.sv ----
// Constants, state encodings and state records for the boot loader
package bpl_pkg;

  localparam logic [2:0]  MODE_SERIAL     = 3'h0;
  localparam logic [2:0]  MODE_SPI        = 3'h1;
  localparam logic [1:0]  MODE_PAR_HI     = 2'h1;

  localparam logic [2:0]  VS_FAST         = 3'h7;
  localparam logic [2:0]  VS_READ         = 3'h5;
  localparam logic [2:0]  VS_ARRAY        = 3'h6;

  localparam logic [7:0]  OP_FAST         = 8'h0B;
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_ARRAY        = 8'hE8;

  localparam logic [2:0]  DUMMY_FAST      = 3'h1;
  localparam logic [2:0]  DUMMY_READ      = 3'h0;
  localparam logic [2:0]  DUMMY_ARRAY     = 3'h4;

  localparam logic [23:0] FLASH_START     = 24'h000000;
  localparam logic [23:0] ADDR_UP_START   = 24'h000000;
  localparam logic [23:0] ADDR_DOWN_START = 24'h0FFFFF;
  localparam logic [23:0] ADDR_STEP       = 24'h000001;
  localparam logic [23:0] COUNT_STEP      = 24'h000001;

  localparam logic [5:0]  CMD_LAST        = 6'h1F;
  localparam logic [5:0]  BYTE_LAST       = 6'h07;
  localparam logic [5:0]  BIT_STEP        = 6'h01;
  localparam logic [5:0]  DUMMY_BITS_0    = 6'h1F;

  typedef enum logic [1:0] {
    SYS_HOLD = 2'h0,
    SYS_RUN  = 2'h1,
    SYS_DONE = 2'h3
  } bpl_sys_e;

  typedef enum logic [2:0] {
    LNK_IDLE  = 3'h0,
    LNK_CMD   = 3'h1,
    LNK_DUMMY = 3'h3,
    LNK_DATA  = 3'h2,
    LNK_PAR   = 3'h6
  } bpl_lnk_e;

  typedef struct packed {
    bpl_sys_e    state;
    logic        init;
    logic [2:0]  mode;
    logic [2:0]  variant;
    logic        pullup_dis;
    logic        keep;
    logic        start;
    logic        clk_keep;
    logic [23:0] count;
    logic        ack;
    logic [7:0]  data;
    logic        valid;
  } bpl_sys_s;

  typedef struct packed {
    bpl_lnk_e    state;
    logic        config_clock;
    logic [31:0] shreg;
    logic [5:0]  bitcnt;
    logic [7:0]  inbyte;
    logic [7:0]  byte_out;
    logic        req;
    logic [23:0] addr;
    logic        sel_n;
    logic        ce_n;
    logic        oe_n;
  } bpl_lnk_s;

endpackage : bpl_pkg

// ---- bpl_sync.sv ----
// Two-stage level synchroniser
module bpl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } bpl_sync_s;

  bpl_sync_s s;
  bpl_sync_s next_s;

  always_comb
  begin
    next_s      = s;
    next_s.meta = d_i;
    next_s.out  = s.meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign q_o = s.out;

endmodule : bpl_sync

// ---- bpl_loader.sv ----
// Configuration loader: serial, flash and parallel PROM fetch
module bpl_loader (
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Link clock (internal oscillator)
  input  wire logic        osc_clk_i,
  // Board straps and control pins
  input  wire logic        program_request_n_i,
  input  wire logic [2:0]  mode_pins_i,
  input  wire logic [2:0]  flash_variant_pins_i,
  input  wire logic        pullup_disable_i,
  input  wire logic        keep_port_i,
  // Loader setup
  input  wire logic [23:0] image_bytes_i,
  // Status pins
  output logic             init_o,
  output logic             done_o,
  output logic             user_pins_released_o,
  output logic             pullups_active_o,
  output logic             config_port_kept_o,
  output logic             upper_addr_reserved_o,
  output logic             chain_select_out_n_o,
  output logic             chain_select_oe_o,
  output logic             busy_o,
  output logic             busy_oe_o,
  // Configuration byte stream
  output logic [7:0]       cfg_byte_o,
  output logic             cfg_byte_valid_o,
  // Link pins, on the oscillator clock
  output logic             config_clock_o,
  output logic             config_clock_oe_o,
  input  wire logic        serial_data_i,
  output logic             flash_select_n_o,
  output logic             flash_mosi_o,
  output logic [23:0]      prom_addr_o,
  input  wire logic [7:0]  prom_data_i,
  output logic             prom_chip_enable_n_o,
  output logic             prom_output_enable_n_o,
  output logic             prom_pins_oe_o
);

  bpl_pkg::bpl_sys_s s;
  bpl_pkg::bpl_sys_s next_s;
  bpl_pkg::bpl_lnk_s l;
  bpl_pkg::bpl_lnk_s next_l;

  logic       prog_s;
  logic [2:0] mode_s;
  logic [2:0] variant_s;
  logic       pullup_s;
  logic       keep_s;
  logic       req_s;
  logic       start_l;
  logic       keep_l;
  logic       ack_l;
  logic       waiting;
  logic       tick;
  logic       rise;
  logic       fall;
  logic       scan_direction_bit;

  function automatic logic [7:0] op_of(input logic [2:0] v);
    case (v)
      bpl_pkg::VS_FAST:  op_of = bpl_pkg::OP_FAST;
      bpl_pkg::VS_ARRAY: op_of = bpl_pkg::OP_ARRAY;
      default:           op_of = bpl_pkg::OP_READ;
    endcase
  endfunction : op_of

  function automatic logic [2:0] dummy_of(input logic [2:0] v);
    case (v)
      bpl_pkg::VS_FAST:  dummy_of = bpl_pkg::DUMMY_FAST;
      bpl_pkg::VS_ARRAY: dummy_of = bpl_pkg::DUMMY_ARRAY;
      default:           dummy_of = bpl_pkg::DUMMY_READ;
    endcase
  endfunction : dummy_of

  // Pin and cross-domain synchronisers
  bpl_sync #(.W(9)) u_sync_pins (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({program_request_n_i, mode_pins_i, flash_variant_pins_i,
                pullup_disable_i, keep_port_i}),
    .q_o     ({prog_s, mode_s, variant_s, pullup_s, keep_s})
  );

  bpl_sync #(.W(1)) u_sync_req (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (l.req),
    .q_o     (req_s)
  );

  bpl_sync #(.W(3)) u_sync_link (
    .clk_i   (osc_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({s.start, s.clk_keep, s.ack}),
    .q_o     ({start_l, keep_l, ack_l})
  );

  // System side sequencing
  always_comb
  begin
    next_s       = s;
    next_s.valid = 1'b0;
    next_s.ack   = req_s;
    case (s.state)
      bpl_pkg::SYS_HOLD:
      begin
        next_s.count = '0;
        if (prog_s)
        begin
          next_s.state      = bpl_pkg::SYS_RUN;
          next_s.init       = 1'b1;
          next_s.mode       = mode_s;
          next_s.variant    = variant_s;
          next_s.pullup_dis = pullup_s;
          next_s.keep       = keep_s;
        end
      end
      bpl_pkg::SYS_RUN:
      begin
        if (req_s != s.ack)
        begin
          next_s.data  = l.byte_out;
          next_s.valid = 1'b1;
          next_s.count = s.count + bpl_pkg::COUNT_STEP;
          if (next_s.count == image_bytes_i)
            next_s.state = bpl_pkg::SYS_DONE;
        end
      end
      bpl_pkg::SYS_DONE:
        next_s.state = bpl_pkg::SYS_DONE;
      default:
        next_s.state = bpl_pkg::SYS_HOLD;
    endcase
    if (!prog_s)
    begin
      next_s.state = bpl_pkg::SYS_HOLD;
      next_s.init  = 1'b0;
    end
    next_s.start    = (next_s.state == bpl_pkg::SYS_RUN);
    next_s.clk_keep = (next_s.state == bpl_pkg::SYS_DONE) && next_s.keep;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign init_o                = s.init;
  assign done_o                = (s.state == bpl_pkg::SYS_DONE);
  assign user_pins_released_o  = done_o;
  assign pullups_active_o      = !s.pullup_dis && !done_o;
  assign config_port_kept_o    = done_o && s.keep;
  assign upper_addr_reserved_o = done_o && s.keep;
  assign chain_select_out_n_o  = 1'b1;
  assign chain_select_oe_o     = !done_o;
  assign busy_o                = 1'b0;
  assign busy_oe_o             = !done_o;
  assign cfg_byte_o            = s.data;
  assign cfg_byte_valid_o      = s.valid;

  // Link side, on the oscillator clock
  assign scan_direction_bit = s.mode[0];

  always_comb
  begin
    next_l  = l;
    waiting = (l.req != ack_l);
    tick    = !waiting && ((l.state != bpl_pkg::LNK_IDLE) || keep_l);
    rise    = tick && !l.config_clock;
    fall    = tick && l.config_clock;
    if (tick)
      next_l.config_clock = !l.config_clock;
    case (l.state)
      bpl_pkg::LNK_IDLE:
      begin
        if (start_l)
        begin
          if (s.mode == bpl_pkg::MODE_SERIAL)
          begin
            next_l.state  = bpl_pkg::LNK_DATA;
            next_l.bitcnt = bpl_pkg::BYTE_LAST;
          end
          else if (s.mode == bpl_pkg::MODE_SPI)
          begin
            next_l.state  = bpl_pkg::LNK_CMD;
            next_l.shreg  = {op_of(s.variant), bpl_pkg::FLASH_START};
            next_l.bitcnt = bpl_pkg::CMD_LAST;
            next_l.sel_n  = 1'b0;
          end
          else if (s.mode[2:1] == bpl_pkg::MODE_PAR_HI)
          begin
            next_l.state = bpl_pkg::LNK_PAR;
            next_l.addr  = scan_direction_bit ? bpl_pkg::ADDR_DOWN_START
                                              : bpl_pkg::ADDR_UP_START;
            next_l.ce_n  = 1'b0;
            next_l.oe_n  = 1'b0;
          end
        end
      end
      bpl_pkg::LNK_CMD:
      begin
        if (fall)
        begin
          next_l.shreg  = {l.shreg[30:0], 1'b0};
          next_l.bitcnt = l.bitcnt - bpl_pkg::BIT_STEP;
          if (l.bitcnt == '0)
          begin
            if (dummy_of(s.variant) == bpl_pkg::DUMMY_READ)
            begin
              next_l.state  = bpl_pkg::LNK_DATA;
              next_l.bitcnt = bpl_pkg::BYTE_LAST;
            end
            else
            begin
              next_l.state  = bpl_pkg::LNK_DUMMY;
              next_l.bitcnt = {dummy_of(s.variant), 3'h0} - bpl_pkg::BIT_STEP;
            end
          end
        end
      end
      bpl_pkg::LNK_DUMMY:
      begin
        if (fall)
        begin
          next_l.bitcnt = l.bitcnt - bpl_pkg::BIT_STEP;
          if (l.bitcnt == '0)
          begin
            next_l.state  = bpl_pkg::LNK_DATA;
            next_l.bitcnt = bpl_pkg::BYTE_LAST;
          end
        end
      end
      bpl_pkg::LNK_DATA:
      begin
        if (rise)
        begin
          next_l.inbyte = {l.inbyte[6:0], serial_data_i};
          next_l.bitcnt = l.bitcnt - bpl_pkg::BIT_STEP;
          if (l.bitcnt == '0)
          begin
            next_l.byte_out = {l.inbyte[6:0], serial_data_i};
            next_l.req      = !l.req;
            next_l.bitcnt   = bpl_pkg::BYTE_LAST;
          end
        end
      end
      bpl_pkg::LNK_PAR:
      begin
        if (rise)
        begin
          next_l.byte_out = prom_data_i;
          next_l.req      = !l.req;
          next_l.addr     = scan_direction_bit ? l.addr - bpl_pkg::ADDR_STEP
                                               : l.addr + bpl_pkg::ADDR_STEP;
        end
      end
      default:
        next_l.state = bpl_pkg::LNK_IDLE;
    endcase
    if (!start_l)
    begin
      next_l.state = bpl_pkg::LNK_IDLE;
      next_l.sel_n = 1'b1;
      next_l.ce_n  = 1'b1;
      next_l.oe_n  = 1'b1;
      if (!keep_l)
        next_l.config_clock = 1'b0;
    end
  end

  always_ff @(posedge osc_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      l       <= '0;
      l.sel_n <= 1'b1;
      l.ce_n  <= 1'b1;
      l.oe_n  <= 1'b1;
    end
    else
      l <= next_l;
  end

  assign config_clock_o         = l.config_clock;
  assign config_clock_oe_o      = start_l || keep_l;
  assign flash_select_n_o       = l.sel_n;
  assign flash_mosi_o           = l.shreg[31];
  assign prom_addr_o            = l.addr;
  assign prom_chip_enable_n_o   = l.ce_n;
  assign prom_output_enable_n_o = l.oe_n;
  assign prom_pins_oe_o         = (l.state == bpl_pkg::LNK_PAR);

  // Checks
  property p_mode_sample;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(s.init) |-> (s.mode == $past(mode_s));
  endproperty
  a_mode_sample: assert property (p_mode_sample)
    else $error("mode not sampled at init release");

  property p_release;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(done_o) |-> user_pins_released_o && !busy_oe_o && !chain_select_oe_o;
  endproperty
  a_release: assert property (p_release)
    else $error("pins not released at done");

  property p_drive_during;
    @(posedge clk_i) disable iff (!rst_b_i)
    (s.state == bpl_pkg::SYS_RUN) |-> busy_oe_o && chain_select_oe_o;
  endproperty
  a_drive_during: assert property (p_drive_during)
    else $error("unused outputs not driven during load");

  property p_upper_addr;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(done_o) && s.keep |-> upper_addr_reserved_o ##1 upper_addr_reserved_o;
  endproperty
  a_upper_addr: assert property (p_upper_addr)
    else $error("upper address lines not reserved");

  property p_fast_op;
    @(posedge osc_clk_i) disable iff (!rst_b_i)
    $rose(l.state == bpl_pkg::LNK_CMD) && (s.variant == bpl_pkg::VS_FAST)
      |-> (l.shreg == 32'h0B000000) && !flash_select_n_o;
  endproperty
  a_fast_op: assert property (p_fast_op)
    else $error("fast read opcode wrong");

  property p_plain_read;
    @(posedge osc_clk_i) disable iff (!rst_b_i)
    (l.state == bpl_pkg::LNK_CMD) && (s.variant == bpl_pkg::VS_READ) && start_l
      ##1 (l.state != bpl_pkg::LNK_CMD) && start_l
      |-> (l.state == bpl_pkg::LNK_DATA) && (l.bitcnt == 6'h07);
  endproperty
  a_plain_read: assert property (p_plain_read)
    else $error("plain read must skip no dummy bytes");

  property p_array_dummy;
    @(posedge osc_clk_i) disable iff (!rst_b_i)
    $rose(l.state == bpl_pkg::LNK_DUMMY) && (s.variant == bpl_pkg::VS_ARRAY)
      |-> (l.bitcnt == bpl_pkg::DUMMY_BITS_0);
  endproperty
  a_array_dummy: assert property (p_array_dummy)
    else $error("array read dummy count wrong");

  property p_scan_start;
    @(posedge osc_clk_i) disable iff (!rst_b_i)
    $rose(l.state == bpl_pkg::LNK_PAR)
      |-> (l.addr == (s.mode[0] ? 24'h0FFFFF : 24'h000000));
  endproperty
  a_scan_start: assert property (p_scan_start)
    else $error("parallel scan start address wrong");

  property p_prom_enables;
    @(posedge osc_clk_i) disable iff (!rst_b_i)
    (l.state == bpl_pkg::LNK_PAR)
      |-> !prom_chip_enable_n_o && !prom_output_enable_n_o;
  endproperty
  a_prom_enables: assert property (p_prom_enables)
    else $error("PROM enables not low during load");

  property p_clock_stop;
    @(posedge osc_clk_i) disable iff (!rst_b_i)
    (!start_l && !keep_l) [*2] |-> !config_clock_o ##1 !config_clock_o;
  endproperty
  a_clock_stop: assert property (p_clock_stop)
    else $error("config clock runs after load");

  c_flash_data: cover property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    $rose(l.state == bpl_pkg::LNK_DATA) && (s.mode == bpl_pkg::MODE_SPI));
  c_par_scan: cover property (@(posedge osc_clk_i) disable iff (!rst_b_i)
    (l.state == bpl_pkg::LNK_PAR) && $changed(l.req));
  c_done: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(done_o));

endmodule : bpl_loader

// ---- bpl_prom_model.sv ----
// Behavioural serial flash, serial PROM and parallel PROM for the loader
module bpl_prom_model (
  // Link pins from the loader
  input  wire logic        config_clock_i,
  input  wire logic        active_i,
  input  wire logic        flash_mosi_i,
  input  wire logic [6:0]  skip_bits_i,
  input  wire logic [23:0] prom_addr_i,
  input  wire logic        prom_chip_enable_n_i,
  input  wire logic        prom_output_enable_n_i,
  // Data back to the loader
  output logic             serial_data_o,
  output logic [7:0]       prom_data_o,
  output logic [31:0]      cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int         rises  = 0;
  int         idx;
  logic [7:0] cur;
  logic [7:0] word;
  logic       last_q = 1'b0;

  // Command capture on rising clock, MSB first
  always @(posedge config_clock_i or negedge active_i)
    if (!active_i)
    begin
      rises <= 0;
      cmd_o <= 32'h0000_0000;
    end
    else
    begin
      rises  <= rises + 1;
      last_q <= serial_data_o;
      if (rises < 32)
        cmd_o <= {cmd_o[30:0], flash_mosi_i};
    end

  // Data bits MSB first once command and dummies are over
  always_comb
  begin
    idx  = rises - int'(skip_bits_i);
    cur  = 8'(idx / 8) * 8'h1D ^ 8'hC3;
    serial_data_o = (active_i && idx >= 0) ? cur[7 - idx % 8] : ~last_q;
  end

  // Parallel PROM drives the true word only while selected and enabled, its inverse otherwise
  assign word = prom_addr_i[7:0] ^ prom_addr_i[19:12] ^ 8'h5A;
  assign prom_data_o = (!prom_chip_enable_n_i && !prom_output_enable_n_i) ?
                       word : ~word;
endmodule : bpl_prom_model

// ---- tb_top.sv ----
// Self-checking bench for the boot configuration loader
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 0, rst_b_i = 0, osc_clk_i = 0;
  logic        program_request_n_i = 0, pullup_disable_i = 0;
  logic        keep_port_i = 0, flash_mode = 0;
  logic [2:0]  mode_pins_i = 0, flash_variant_pins_i = 0;
  logic [23:0] image_bytes_i = 24'h000004;
  logic [6:0]  skip = 0;
  logic        init_o, done_o, user_pins_released_o, pullups_active_o;
  logic        config_port_kept_o, upper_addr_reserved_o;
  logic        chain_select_out_n_o, chain_select_oe_o, busy_o, busy_oe_o;
  logic [7:0]  cfg_byte_o, prom_data_i;
  logic        cfg_byte_valid_o, config_clock_o, config_clock_oe_o;
  logic        serial_data_i, flash_select_n_o, flash_mosi_o;
  logic [23:0] prom_addr_o;
  logic        prom_chip_enable_n_o, prom_output_enable_n_o, prom_pins_oe_o;
  logic [31:0] cmd;
  int          n_fail = 0, checked = 0, cycles = 0;
  logic [7:0]  ops[3] = '{8'h0B, 8'h03, 8'hE8};
  logic [2:0]  vsel[3] = '{3'h7, 3'h5, 3'h6};
  int          dum[3] = '{1, 0, 4};

  bpl_loader u_dut (
    .clk_i, .rst_b_i, .osc_clk_i, .program_request_n_i, .mode_pins_i,
    .flash_variant_pins_i, .pullup_disable_i, .keep_port_i, .image_bytes_i,
    .init_o, .done_o, .user_pins_released_o, .pullups_active_o,
    .config_port_kept_o, .upper_addr_reserved_o, .chain_select_out_n_o,
    .chain_select_oe_o, .busy_o, .busy_oe_o, .cfg_byte_o, .cfg_byte_valid_o,
    .config_clock_o, .config_clock_oe_o, .serial_data_i, .flash_select_n_o,
    .flash_mosi_o, .prom_addr_o, .prom_data_i, .prom_chip_enable_n_o,
    .prom_output_enable_n_o, .prom_pins_oe_o
  );

  bpl_prom_model u_prom (
    .config_clock_i         (config_clock_o),
    .active_i               (flash_mode ? !flash_select_n_o : config_clock_oe_o),
    .flash_mosi_i           (flash_mosi_o),
    .skip_bits_i            (skip),
    .prom_addr_i            (prom_addr_o),
    .prom_chip_enable_n_i   (prom_chip_enable_n_o),
    .prom_output_enable_n_i (prom_output_enable_n_o),
    .serial_data_o          (serial_data_i),
    .prom_data_o            (prom_data_i),
    .cmd_o                  (cmd)
  );

  initial
    forever #10 clk_i = ~clk_i;

  initial
  begin
    #7;
    forever #15 osc_clk_i = ~osc_clk_i;
  end

  function automatic logic [7:0] expect_byte(input int kind, input int k);
    logic [23:0] a;
    a = (kind == 2) ? 24'h0FFFFF - 24'(k) : 24'(k);
    return (kind == 0) ? 8'(k) * 8'h1D ^ 8'hC3 : a[7:0] ^ a[19:12] ^ 8'h5A;
  endfunction : expect_byte

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic start_run(input logic [2:0] m, input logic [2:0] v,
                           input logic k, input logic pd);
    step();
    rst_b_i = 0;
    program_request_n_i = 0;
    mode_pins_i = m;
    flash_variant_pins_i = v;
    keep_port_i = k;
    pullup_disable_i = pd;
    repeat (2) step();
    rst_b_i = 1;
    repeat (3) step();
    program_request_n_i = 1;
    for (int i = 0; i < 10 && init_o !== 1'b1; i++)
      step();
    `CHK(init_o, 1'b1)
    `CHK({chain_select_oe_o, busy_oe_o, chain_select_out_n_o, busy_o}, 4'hE)
    `CHK(pullups_active_o, !pd)
  endtask : start_run

  task automatic take_bytes(input int from, input int to, input int kind);
    int t;
    for (int k = from; k < to; k++)
    begin
      t = 0;
      while (cfg_byte_valid_o !== 1'b1 && t < 3000)
      begin
        step();
        t++;
      end
      `CHK(cfg_byte_valid_o, 1'b1)
      `CHK(cfg_byte_o, expect_byte(kind, k))
      step();
    end
  endtask : take_bytes

  task automatic finish_load(input string name, input logic k);
    logic c0;
    logic moved;
    repeat (8) step();
    `CHK(done_o, 1'b1)
    `CHK(user_pins_released_o, 1'b1)
    `CHK({chain_select_oe_o, busy_oe_o}, 2'b00)
    `CHK({config_port_kept_o, upper_addr_reserved_o}, {k, k})
    `CHK(prom_chip_enable_n_o, 1'b1)
    `CHK(pullups_active_o, 1'b0)
    c0 = config_clock_o;
    moved = 0;
    repeat (20)
    begin
      step();
      if (config_clock_o !== c0)
        moved = 1;
    end
    `CHK(moved, k)
    $display("Test %s finished", name);
  endtask : finish_load

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    // Serial PROM, straps changed after sampling
    start_run(3'h0, 3'h7, 1'b0, 1'b1);
    mode_pins_i = 3'h1;
    take_bytes(0, 1, 0);
    `CHK({config_clock_oe_o, flash_select_n_o}, 2'b11)
    take_bytes(1, 4, 0);
    finish_load("serial", 1'b0);
    // Flash variants, keep option on the second
    flash_mode = 1;
    for (int i = 0; i < 3; i++)
    begin
      skip = 7'(32 + 8 * dum[i]);
      start_run(3'h1, vsel[i], i == 1, i[0]);
      take_bytes(0, 4, 0);
      `CHK(cmd, {ops[i], 24'h000000})
      `CHK(flash_select_n_o, 1'b0)
      finish_load("flash", i == 1);
    end
    // Abort by program request, then a full reload
    skip = 7'd40;
    start_run(3'h1, 3'h7, 1'b0, 1'b0);
    take_bytes(0, 2, 0);
    program_request_n_i = 0;
    repeat (5) step();
    `CHK({init_o, done_o}, 2'b00)
    program_request_n_i = 1;
    take_bytes(0, 4, 0);
    finish_load("abort", 1'b0);
    // Parallel PROM scans up and down
    flash_mode = 0;
    for (int d = 0; d < 2; d++)
    begin
      start_run({2'b01, d[0]}, 3'h5, 1'b0, 1'b0);
      take_bytes(0, 3, 1 + d);
      `CHK({prom_chip_enable_n_o, prom_output_enable_n_o}, 2'b00)
      `CHK(prom_pins_oe_o, 1'b1)
      take_bytes(3, 4, 1 + d);
      finish_load("parallel", 1'b0);
    end
    complete_run();
  end
endmodule : tb_top
